// ### verilog/host_buffer_pkg.sv
// Purpose: constants for host buffer handshake logic
// Assumes: 25 MHz sys_clk, AXI4-Lite register access
// Notes: Behaviour list below
// Behaviour
// - host hands tx buffer; device clears
// - bad tx count write flags tx error
// - tx zero means empty, device-written
// - count in bits 3..0, rx 1..8
// - device sets rx count; host resets
// - bad rx reset flags rx error
// - publish 16-bit symbol store target
// - fetch address from round-trip delay
// - after publish, owner FF, interrupt
// - on 00 device copies, restores FF
// - owner 00 device, FF host
// - late host service sets symbol error
// - rx filled: set status, interrupt
// - tx emptied: raise interrupt
package host_buffer_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_TX0 = 8'h00;
  localparam logic [7:0] ADDR_TX1 = 8'h04;
  localparam logic [7:0] ADDR_RX0 = 8'h08;
  localparam logic [7:0] ADDR_RX1 = 8'h0C;
  localparam logic [7:0] ADDR_OWNER = 8'h10;
  localparam logic [7:0] ADDR_ERR = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_BASE = 8'h1C;
  localparam logic [7:0] ADDR_TOP = 8'h20;
  localparam logic [7:0] ADDR_DELAY = 8'h24;
  localparam logic [7:0] ADDR_STORE = 8'h28;
  localparam logic [7:0] ADDR_FETCH = 8'h2C;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_SETUP_BIT = 2;
  localparam int ERR_TX_BIT = 0;
  localparam int ERR_RX_BIT = 1;
  localparam int SYMBOL_DEADLINE_ERROR_BIT = 2;
  localparam logic [3:0] MAX_COUNT = 4'h8;
  localparam logic [7:0] OWNER_DEVICE = 8'h00;
  localparam logic [7:0] OWNER_HOST = 8'hFF;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [2:0] ERR_RST = 3'h0;
  localparam logic [15:0] ADDR16_RST = 16'h0000;
  localparam logic [16:0] SYM_STEP = 17'h00008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SYM_DEADLINE_NS = 3300000;
  localparam int SYM_DEADLINE_CYC = SYM_DEADLINE_NS / CLK_PERIOD_NS;
  typedef enum logic [0:0] {
    SYM_IDLE = 1'b0,
    SYM_HOST = 1'b1
  } sym_state_t;
endpackage : host_buffer_pkg

// ### verilog/delay_addr_gen.sv
// Purpose: circular store and fetch addresses for the delay area
// Assumes: delay below the area span
// Notes: advance publishes next slot
`timescale 1ns/1ps
module delay_addr_gen
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // control
  input  wire logic        init,
  input  wire logic        advance,
  input  wire logic [15:0] baseAddr,
  input  wire logic [15:0] topAddr,
  input  wire logic [15:0] delay,
  // addresses
  output logic      [15:0] storeAddr,
  output logic      [15:0] fetchAddr
);
  import host_buffer_pkg::*;
  logic [15:0] nextQ;
  logic [16:0] span;
  logic [16:0] offs;
  logic [16:0] inc;
  logic [16:0] back;

  always_comb
  begin
    span = {1'b0, topAddr} - {1'b0, baseAddr} + 17'h00001;
    offs = {1'b0, nextQ} - {1'b0, baseAddr};
    inc = {1'b0, nextQ} + SYM_STEP;
    if (inc > {1'b0, topAddr})
      inc = inc - span;
    // fetch trails store by the round-trip delay
    if (offs >= {1'b0, delay})
      back = {1'b0, nextQ} - {1'b0, delay};
    else
      back = {1'b0, nextQ} + span - {1'b0, delay};
  end

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      nextQ <= ADDR16_RST;
      storeAddr <= ADDR16_RST;
      fetchAddr <= ADDR16_RST;
    end
    else if (init)
    begin
      nextQ <= baseAddr;
      storeAddr <= baseAddr;
      fetchAddr <= baseAddr;
    end
    else if (advance)
    begin
      storeAddr <= nextQ;
      fetchAddr <= back[15:0];
      nextQ <= inc[15:0];
    end
  end
endmodule : delay_addr_gen

// ### verilog/host_buffer_handshake.sv
// Purpose: buffer status handshake between modem core and host
// Assumes: core strobes are on sys_clk; AXI4-Lite master
// Notes: symbol data lives in shared RAM outside this block
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
module host_buffer_handshake
#(
  parameter int DEADLINE_CYC = host_buffer_pkg::SYM_DEADLINE_CYC
)
(
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      resetn,
  // axi write address and data
  input  wire logic [host_buffer_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  // axi write response
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // axi read
  input  wire logic [host_buffer_pkg::ADDR_W-1:0] araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // transmitter side
  input  wire logic                      txTake,
  output logic                           txReady,
  output logic [3:0]                     txLength,
  output logic                           txBufIdx,
  // receiver side
  input  wire logic                      rxFill,
  input  wire logic [3:0]                rxFillCount,
  output logic                           rxAvail,
  output logic                           rxBufIdx,
  // symbol exchange
  input  wire logic                      symGathered,
  output logic                           symCopy,
  // host interrupts
  output logic                           txBufferInterrupt,
  output logic                           rxBufferInterrupt,
  output logic                           symbolBufferInterrupt
);
  import host_buffer_pkg::*;

  logic [7:0]  txCountQ [2];
  logic [7:0]  rxCountQ [2];
  logic        txSelQ;
  logic        rxSelQ;
  logic        txRunQ;
  logic [7:0]  ownerQ;
  logic [2:0]  errQ;
  logic [15:0] baseQ;
  logic [15:0] topQ;
  logic [15:0] delayQ;
  logic [15:0] storeAddr;
  logic [15:0] fetchAddr;
  sym_state_t  symStateQ;
  logic [16:0] waitQ;
  logic        lateSeenQ;
  logic        awreadyQ;
  logic        wreadyQ;
  logic        bvalidQ;
  logic [1:0]  brespQ;
  logic        arreadyQ;
  logic        rvalidQ;
  logic [1:0]  rrespQ;
  logic [31:0] rdataQ;
  logic        txIrqQ;
  logic        rxIrqQ;
  logic        symIrqQ;
  logic        symCopyQ;
  logic        txReadyQ;
  logic [3:0]  txLengthQ;
  logic        rxAvailQ;

  logic        wHit;
  logic        wrTx;
  logic        wrRx;
  logic        wrOwn;
  logic        wrErr;
  logic        wrCtrl;
  logic        wIdx;
  logic        txBad;
  logic        rxBad;
  logic        wMapped;
  logic        txTakeOk;
  logic        rxFillOk;
  logic        symStart;
  logic        symLate;
  logic        setupInit;
  logic        rMapped;
  logic [31:0] rWord;

  // a write is taken in the cycle both readies are high
  assign wHit = awreadyQ && wreadyQ;
  assign wIdx = awaddr[2];

  always_comb
  begin
    wrTx = 1'b0;
    wrRx = 1'b0;
    wrOwn = 1'b0;
    wrErr = 1'b0;
    wrCtrl = 1'b0;
    wMapped = 1'b1;
    if (awaddr == ADDR_TX0 || awaddr == ADDR_TX1)
      wrTx = wHit && wstrb[0];
    else if (awaddr == ADDR_RX0 || awaddr == ADDR_RX1)
      wrRx = wHit && wstrb[0];
    else if (awaddr == ADDR_OWNER)
      wrOwn = wHit && wstrb[0];
    else if (awaddr == ADDR_ERR)
      wrErr = wHit && wstrb[0];
    else if (awaddr == ADDR_CTRL)
      wrCtrl = wHit && wstrb[0];
    else if (awaddr != ADDR_BASE && awaddr != ADDR_TOP
             && awaddr != ADDR_DELAY)
      wMapped = 1'b0;
  end

  // zero, over eight, stray high bits or a busy buffer are misuse
  assign txBad = wdata[7:4] != 4'h0 || wdata[3:0] == 4'h0
                 || wdata[3:0] > MAX_COUNT
                 || txCountQ[wIdx] != COUNT_RST;
  // only zero may be written, and only to a full buffer
  assign rxBad = wdata[7:0] != COUNT_RST
                 || rxCountQ[wIdx] == COUNT_RST;

  assign txTakeOk = txTake && txRunQ
                    && txCountQ[txSelQ] != COUNT_RST;
  // availability checked right before filling
  assign rxFillOk = rxFill && rxCountQ[rxSelQ] == COUNT_RST
                    && rxFillCount != 4'h0
                    && rxFillCount <= MAX_COUNT;
  assign symStart = symStateQ == SYM_IDLE && symGathered;
  assign symLate = symStateQ == SYM_HOST && !lateSeenQ
                   && waitQ == 17'(DEADLINE_CYC - 1);
  assign setupInit = wrCtrl && wdata[CTRL_SETUP_BIT];

  // axi write channel
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      awreadyQ <= 1'b0;
      wreadyQ <= 1'b0;
      bvalidQ <= 1'b0;
      brespQ <= RESP_OKAY;
    end
    else
    begin
      awreadyQ <= awvalid && wvalid && !awreadyQ && !bvalidQ;
      wreadyQ <= awvalid && wvalid && !awreadyQ && !bvalidQ;
      if (wHit)
      begin
        bvalidQ <= 1'b1;
        brespQ <= wMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalidQ <= 1'b0;
    end
  end

  // transmit buffers: host fills, device empties
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      txCountQ[0] <= COUNT_RST;
      txCountQ[1] <= COUNT_RST;
      txSelQ <= 1'b0;
      txRunQ <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (txTakeOk && txSelQ == 1'(i))
          txCountQ[i] <= COUNT_RST;
        else if (wrTx && !txBad && wIdx == 1'(i))
          txCountQ[i] <= wdata[7:0];
      end
      if (txTakeOk)
        txSelQ <= !txSelQ;
      if (wrCtrl && wdata[CTRL_STOP_BIT])
      begin
        txRunQ <= 1'b0;
        txSelQ <= 1'b0;
      end
      else if (wrCtrl && wdata[CTRL_START_BIT])
        txRunQ <= 1'b1;
    end
  end

  // receive buffers: device fills, host frees
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      rxCountQ[0] <= COUNT_RST;
      rxCountQ[1] <= COUNT_RST;
      rxSelQ <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (rxFillOk && rxSelQ == 1'(i))
          rxCountQ[i] <= {4'h0, rxFillCount};
        else if (wrRx && !rxBad && wIdx == 1'(i))
          rxCountQ[i] <= COUNT_RST;
      end
      if (rxFillOk)
        rxSelQ <= !rxSelQ;
    end
  end

  // symbol ownership handshake
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      symStateQ <= SYM_IDLE;
      ownerQ <= OWNER_HOST;
      symCopyQ <= 1'b0;
    end
    else
    begin
      symCopyQ <= 1'b0;
      case (symStateQ)
        SYM_IDLE:
        begin
          if (symGathered)
          begin
            ownerQ <= OWNER_HOST;
            symStateQ <= SYM_HOST;
          end
        end
        SYM_HOST:
        begin
          // host write lands first, copy seen next cycle
          if (ownerQ == OWNER_DEVICE)
          begin
            symCopyQ <= 1'b1;
            ownerQ <= OWNER_HOST;
            symStateQ <= SYM_IDLE;
          end
          else if (wrOwn && wdata[7:0] == OWNER_DEVICE)
            ownerQ <= OWNER_DEVICE;
        end
        default:
          symStateQ <= SYM_IDLE;
      endcase
    end
  end

  // service deadline, counted from the interrupt
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      waitQ <= 17'h00000;
      lateSeenQ <= 1'b0;
    end
    else if (symStart)
    begin
      waitQ <= 17'h00000;
      lateSeenQ <= 1'b0;
    end
    else if (symStateQ == SYM_HOST && !lateSeenQ)
    begin
      waitQ <= waitQ + 17'h00001;
      if (symLate)
        lateSeenQ <= 1'b1;
    end
  end

  // sticky errors, a new event beats a clear
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
      errQ <= ERR_RST;
    else
      errQ <= (errQ & ~(wrErr ? wdata[2:0] : 3'h0))
              | {symLate, wrRx && rxBad, wrTx && txBad};
  end

  // delay area setup
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      baseQ <= ADDR16_RST;
      topQ <= ADDR16_RST;
      delayQ <= ADDR16_RST;
    end
    else if (wHit && wstrb[1:0] == 2'h3)
    begin
      if (awaddr == ADDR_BASE)
        baseQ <= wdata[15:0];
      else if (awaddr == ADDR_TOP)
        topQ <= wdata[15:0];
      else if (awaddr == ADDR_DELAY)
        delayQ <= wdata[15:0];
    end
  end

  delay_addr_gen u_addr (
    .sys_clk   (sys_clk),
    .resetn    (resetn),
    .init      (setupInit),
    .advance   (symStart),
    .baseAddr  (baseQ),
    .topAddr   (topQ),
    .delay     (delayQ),
    .storeAddr (storeAddr),
    .fetchAddr (fetchAddr)
  );

  // core-facing outputs and interrupt pulses
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      txIrqQ <= 1'b0;
      rxIrqQ <= 1'b0;
      symIrqQ <= 1'b0;
      txReadyQ <= 1'b0;
      txLengthQ <= 4'h0;
      rxAvailQ <= 1'b0;
    end
    else
    begin
      txIrqQ <= txTakeOk;
      rxIrqQ <= rxFillOk;
      symIrqQ <= symStart;
      txReadyQ <= txRunQ && txCountQ[txSelQ] != COUNT_RST
                  && !txTakeOk;
      txLengthQ <= txCountQ[txSelQ][3:0];
      rxAvailQ <= rxCountQ[rxSelQ] == COUNT_RST && !rxFillOk;
    end
  end

  // read mux
  always_comb
  begin
    rWord = 32'h00000000;
    rMapped = 1'b1;
    if (araddr == ADDR_TX0)
      rWord[7:0] = txCountQ[0];
    else if (araddr == ADDR_TX1)
      rWord[7:0] = txCountQ[1];
    else if (araddr == ADDR_RX0)
      rWord[7:0] = rxCountQ[0];
    else if (araddr == ADDR_RX1)
      rWord[7:0] = rxCountQ[1];
    else if (araddr == ADDR_OWNER)
      rWord[7:0] = ownerQ;
    else if (araddr == ADDR_ERR)
      rWord[2:0] = errQ;
    else if (araddr == ADDR_CTRL)
      rWord[CTRL_START_BIT] = txRunQ;
    else if (araddr == ADDR_BASE)
      rWord[15:0] = baseQ;
    else if (araddr == ADDR_TOP)
      rWord[15:0] = topQ;
    else if (araddr == ADDR_DELAY)
      rWord[15:0] = delayQ;
    else if (araddr == ADDR_STORE)
      rWord[15:0] = storeAddr;
    else if (araddr == ADDR_FETCH)
      rWord[15:0] = fetchAddr;
    else
      rMapped = 1'b0;
  end

  // axi read channel
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      arreadyQ <= 1'b0;
      rvalidQ <= 1'b0;
      rrespQ <= RESP_OKAY;
      rdataQ <= 32'h00000000;
    end
    else
    begin
      arreadyQ <= arvalid && !arreadyQ && !rvalidQ;
      if (arreadyQ)
      begin
        rvalidQ <= 1'b1;
        rdataQ <= rWord;
        rrespQ <= rMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
        rvalidQ <= 1'b0;
    end
  end

  assign awready = awreadyQ;
  assign wready = wreadyQ;
  assign bvalid = bvalidQ;
  assign bresp = brespQ;
  assign arready = arreadyQ;
  assign rvalid = rvalidQ;
  assign rresp = rrespQ;
  assign rdata = rdataQ;
  assign txReady = txReadyQ;
  assign txLength = txLengthQ;
  assign txBufIdx = txSelQ;
  assign rxAvail = rxAvailQ;
  assign rxBufIdx = rxSelQ;
  assign symCopy = symCopyQ;
  assign txBufferInterrupt = txIrqQ;
  assign rxBufferInterrupt = rxIrqQ;
  assign symbolBufferInterrupt = symIrqQ;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_tx_take_irq: assert property (
    txTakeOk |=> txIrqQ ##1 txIrqQ == $past(txTakeOk))
    else $error("tx interrupt not one pulse");
  a_tx_take_clear: assert property (
    txTakeOk |=> txCountQ[$past(txSelQ)] == COUNT_RST
                 && txSelQ != $past(txSelQ))
    else $error("tx buffer not cleared or not swapped");
  a_tx_bad_flag: assert property (
    (wrTx && txBad) |=> errQ[ERR_TX_BIT]
                        && (txCountQ[$past(wIdx)] == $past(txCountQ[wIdx])
                            || $past(txTakeOk)))
    else $error("bad tx write not flagged");
  a_rx_fill_irq: assert property (
    rxFillOk |=> rxIrqQ
                 && rxCountQ[$past(rxSelQ)][3:0] == $past(rxFillCount))
    else $error("rx fill not published");
  a_rx_bad_flag: assert property (
    (wrRx && rxBad) |=> errQ[ERR_RX_BIT])
    else $error("bad rx reset not flagged");
  a_rx_range: assert property (
    rxCountQ[0] <= {4'h0, MAX_COUNT} && rxCountQ[1] <= {4'h0, MAX_COUNT})
    else $error("rx count out of range");
  a_sym_publish: assert property (
    symStart |=> symIrqQ && ownerQ == OWNER_HOST
                 && storeAddr == $past(u_addr.nextQ))
    else $error("symbol publish incomplete");
  a_sym_restore: assert property (
    (symStateQ == SYM_HOST && ownerQ == OWNER_DEVICE)
      |=> symCopyQ && ownerQ == OWNER_HOST ##1 !symCopyQ)
    else $error("symbol copy or restore missing");
  a_sym_late: assert property (
    symLate |=> errQ[SYMBOL_DEADLINE_ERROR_BIT] && lateSeenQ)
    else $error("late symbol service not flagged");
  a_err_sticky: assert property (
    (errQ[ERR_TX_BIT] && !(wrErr && wdata[ERR_TX_BIT]))
      |=> errQ[ERR_TX_BIT])
    else $error("tx error flag lost");

  c_tx_pingpong: cover property (txTakeOk ##[1:50] txTakeOk);
  c_rx_fill: cover property (rxFillOk ##1 rxIrqQ);
  c_sym_round: cover property (symStart ##[1:100] symCopyQ);
  c_sym_late: cover property (symLate);
endmodule : host_buffer_handshake

// ### tb/host_axi_model.sv
// Purpose: host side AXI4-Lite master for the buffer handshake
// Assumes: one write and one read at most under way
// Notes: released address and data lines show their inverse
`timescale 1ns/1ps
module host_axi_model
(
  // clock
  input  wire logic        sys_clk,
  // write channels
  output logic      [7:0]  awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic      [31:0] wdata,
  output logic      [3:0]  wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // read channels
  output logic      [7:0]  araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge sys_clk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    resp = 2'h3;
    // no cycle budget here, the bench watchdog ends a hung wait
    forever
    begin
      @(posedge sys_clk);
      if (awvalid && awready)
        {awvalid, awaddr} <= {1'b0, ~a};
      if (wvalid && wready)
        {wvalid, wdata} <= {1'b0, ~d};
      if (bvalid)
      begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    @(posedge sys_clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    {d, resp} = {32'h0, 2'h3};
    forever
    begin
      @(posedge sys_clk);
      if (arvalid && arready)
        {arvalid, araddr} <= {1'b0, ~a};
      if (rvalid)
      begin
        {d, resp} = {rdata, rresp};
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd
endmodule : host_axi_model

// ### tb/tb_top.sv
// Purpose: self-checking bench for host_buffer_handshake
// Assumes: host model drives AXI, bench drives the core strobes
// Notes: read results queued at issue, compared when rvalid lands
`timescale 1ns/1ps
module tb_top;
  import host_buffer_pkg::*;
  localparam int DL = 40;
  logic        sys_clk, resetn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, txLength, rxFillCount;
  logic [1:0]  bresp, rresp;
  logic        txTake, txReady, txBufIdx, rxFill, rxAvail, rxBufIdx;
  logic        symGathered, symCopy;
  logic        txBufferInterrupt, rxBufferInterrupt;
  logic        symbolBufferInterrupt;
  logic [33:0] expQ[$];
  logic [31:0] seed = 32'h8CBA44B1;
  int          errCount = 0;
  int          nChecks = 0;
  int          txN = 0, rxN = 0, symN = 0, cpyN = 0;

  host_buffer_handshake #(.DEADLINE_CYC(DL)) u_host_buffer_handshake
  (.sys_clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
   .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
   .arready, .rdata, .rresp, .rvalid, .rready, .txTake, .txReady,
   .txLength, .txBufIdx, .rxFill, .rxFillCount, .rxAvail, .rxBufIdx,
   .symGathered, .symCopy, .txBufferInterrupt, .rxBufferInterrupt,
   .symbolBufferInterrupt);

  host_axi_model u_host_axi_model
  (.sys_clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
   .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
   .rdata, .rresp, .rvalid, .rready);

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic testDone();
    $display("checks %0d errors %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : testDone

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    nChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // byte counts 1..8 from the xorshift stream
  function automatic logic [3:0] rnd8();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return {1'b0, seed[2:0]} + 4'h1;
  endfunction : rnd8

  task automatic rdx(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    logic [31:0] dd;
    logic [1:0]  rr;
    expQ.push_back({r, d});
    u_host_axi_model.rd(a, dd, rr);
  endtask : rdx

  task automatic wrx(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] rr;
    u_host_axi_model.wr(a, d, rr);
  endtask : wrx

  // one-cycle strobe: sel is {txTake, rxFill, symGathered}
  task automatic pulse(input logic [2:0] sel, input logic [3:0] cnt);
    @(posedge sys_clk);
    {txTake, rxFill, symGathered, rxFillCount} <= {sel, cnt};
    @(posedge sys_clk);
    {txTake, rxFill, symGathered, rxFillCount} <= {3'b000, ~cnt};
    repeat (3) @(posedge sys_clk);
  endtask : pulse

  always @(posedge sys_clk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1)
      chk({rresp, rdata}, expQ.size() > 0 ? expQ.pop_front() : 34'h1);
    txN  <= txN + 32'(txBufferInterrupt === 1'b1);
    rxN  <= rxN + 32'(rxBufferInterrupt === 1'b1);
    symN <= symN + 32'(symbolBufferInterrupt === 1'b1);
    cpyN <= cpyN + 32'(symCopy === 1'b1);
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errCount++;
    testDone();
  end

  initial
  begin
    logic [3:0]  c0, c1, k0, k1;
    logic [15:0] st;
    logic [1:0]  br;
    {resetn, txTake, rxFill, symGathered, rxFillCount} = '0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rdx(8'(i * 4), i == 4 ? 32'hFF : 32'h0, RESP_OKAY);
    rdx(ADDR_STORE, 32'h0, RESP_OKAY);
    rdx(8'h3C, 32'h0, RESP_SLVERR);
    u_host_axi_model.wr(8'h3C, 32'h1, br);
    chk(34'(br), 34'(RESP_SLVERR));
    c0 = rnd8();
    c1 = rnd8();
    wrx(ADDR_TX0, {28'h0, c0});
    wrx(ADDR_TX1, {28'h0, c1});
    wrx(ADDR_CTRL, 32'h1);
    rdx(ADDR_TX0, {28'h0, c0}, RESP_OKAY);
    chk(34'(txReady), 34'h1);
    chk(34'({txBufIdx, txLength}), 34'({1'b0, c0}));
    pulse(3'b100, 4'h0);
    chk(34'(txN), 34'h1);
    rdx(ADDR_TX0, 32'h0, RESP_OKAY);
    chk(34'({txBufIdx, txLength}), 34'({1'b1, c1}));
    pulse(3'b100, 4'h0);
    rdx(ADDR_TX1, 32'h0, RESP_OKAY);
    chk(34'({txReady, txBufIdx}), 34'h0);
    pulse(3'b100, 4'h0);
    chk(34'(txN), 34'h2);
    wrx(ADDR_TX0, 32'h13);
    wrx(ADDR_TX1, 32'h9);
    rdx(ADDR_ERR, 32'h1, RESP_OKAY);
    rdx(ADDR_TX0, 32'h0, RESP_OKAY);
    repeat (20) @(posedge sys_clk);
    rdx(ADDR_ERR, 32'h1, RESP_OKAY);
    wrx(ADDR_ERR, 32'h1);
    rdx(ADDR_ERR, 32'h0, RESP_OKAY);
    chk(34'({rxAvail, rxBufIdx}), 34'h2);
    k0 = rnd8();
    k1 = rnd8();
    pulse(3'b010, k0);
    chk(34'(rxN), 34'h1);
    rdx(ADDR_RX0, {28'h0, k0}, RESP_OKAY);
    pulse(3'b010, k1);
    rdx(ADDR_RX1, {28'h0, k1}, RESP_OKAY);
    chk(34'(rxAvail), 34'h0);
    pulse(3'b010, 4'h3);
    chk(34'(rxN), 34'h2);
    wrx(ADDR_RX1, 32'h5);
    rdx(ADDR_RX1, {28'h0, k1}, RESP_OKAY);
    rdx(ADDR_ERR, 32'h2, RESP_OKAY);
    wrx(ADDR_ERR, 32'h2);
    wrx(ADDR_RX0, 32'h0);
    rdx(ADDR_ERR, 32'h0, RESP_OKAY);
    chk(34'({rxAvail, rxBufIdx}), 34'h2);
    wrx(ADDR_RX0, 32'h0);
    rdx(ADDR_ERR, 32'h2, RESP_OKAY);
    pulse(3'b010, 4'h9);
    chk(34'(rxN), 34'h2);
    wrx(ADDR_ERR, 32'h7);
    wrx(ADDR_OWNER, 32'h0);
    rdx(ADDR_OWNER, 32'hFF, RESP_OKAY);
    // three slots of eight, so the fourth batch wraps to the base
    wrx(ADDR_BASE, 32'h40);
    wrx(ADDR_TOP, 32'h57);
    wrx(ADDR_DELAY, 32'h8);
    wrx(ADDR_CTRL, 32'h4);
    for (int i = 0; i < 4; i++)
    begin
      st = 16'h0040 + 16'((i % 3) * 8);
      pulse(3'b001, 4'h0);
      chk(34'(symN), 34'(i + 1));
      rdx(ADDR_OWNER, 32'hFF, RESP_OKAY);
      rdx(ADDR_STORE, 32'(st), RESP_OKAY);
      rdx(ADDR_FETCH, 32'(st == 16'h0040 ? 16'h0050 : st - 16'h0008),
          RESP_OKAY);
      if (i == 3)
        repeat (DL + 10) @(posedge sys_clk);
      wrx(ADDR_OWNER, 32'h0);
      repeat (4) @(posedge sys_clk);
      chk(34'(cpyN), 34'(i + 1));
      rdx(ADDR_OWNER, 32'hFF, RESP_OKAY);
      rdx(ADDR_ERR, i == 3 ? 32'h4 : 32'h0, RESP_OKAY);
    end
    wrx(ADDR_ERR, 32'h7);
    rdx(ADDR_ERR, 32'h0, RESP_OKAY);
    repeat (4) @(posedge sys_clk);
    chk(34'(expQ.size()), 34'h0);
    testDone();
  end
endmodule : tb_top
